// *** rstfr_pkg.sv ***
// shared constants, register codes and state type of the rail sequencer
package rstfr_pkg;
    // ****************************************
    // timebase
    // ****************************************
    localparam int CLK_HZ           = 10_000_000;
    localparam int CLK_NS           = 1_000_000_000 / CLK_HZ;
    localparam int TICK_NS          = 10_000;
    localparam int TICK_CYC         = TICK_NS / CLK_NS;
    localparam int SAMPLE_NS        = 12_200;
    localparam int SAMPLE_CYC       = SAMPLE_NS / CLK_NS;
    localparam int TICKS_PER_MS     = 1_000_000 / TICK_NS;
    localparam int TIMER_MAX_MS     = 655;
    localparam int TIMER_MAX_TICKS  = TIMER_MAX_MS * TICKS_PER_MS;
    localparam int TEMP_SCALE       = 16;
    localparam int SHARE_LOSS_TICKS = 2;
    // ****************************************
    // register codes
    // ****************************************
    localparam logic [7:0] REG_OT_FAULT  = 8'h00;
    localparam logic [7:0] REG_TON_WAIT  = 8'h04;
    localparam logic [7:0] REG_OV_REACT  = 8'h08;
    localparam logic [7:0] REG_CTRL      = 8'h0A;
    localparam logic [7:0] REG_STATUS    = 8'h0B;
    localparam logic [7:0] REG_CLEAR     = 8'h0C;
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int ACT_LO   = 6;
    localparam int RETRY_LO = 3;
    localparam int DLY_LO   = 0;
    localparam int CTRL_ON  = 0;
    localparam int CTRL_DAC = 1;
    localparam int CTRL_PIN = 3;
    localparam int CTRL_HRS = 4;
    localparam int ST_OV    = 0;
    localparam int ST_UV    = 1;
    localparam int ST_WORD  = 2;
    localparam int ST_BYTE  = 3;
    localparam logic [15:0] WORD_RST  = 16'h0000;
    localparam logic [7:0]  REACT_RST = 8'h00;
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    // sequencer states
    typedef enum logic [2:0] {
        S_OFF, S_ON_WAIT, S_RAMP, S_UP, S_OFF_WAIT, S_FAULT
    } rstfr_state_t;
endpackage

// *** rstfr_lin_decode.sv ***
// mantissa-exponent word to scaled, rounded and clamped integer
`timescale 1ns/10ps
module rstfr_lin_decode
    import rstfr_pkg::*;
#(
    parameter int SCALE = TICKS_PER_MS,
    parameter int OMIN  = 0,
    parameter int OMAX  = TIMER_MAX_TICKS,
    parameter int W     = 17
) (
    // encoded word
    input  wire logic [15:0]         lin_word,
    // decoded value
    output logic signed [W-1:0]      lin_value
);
    logic signed [39:0] mant_w;
    logic signed [39:0] prod_w;
    logic signed [39:0] half_w;
    logic signed [39:0] shift_w;
    logic signed [5:0]  expo_w;
    logic [4:0]         rsh_w;

    // mantissa and exponent are both two's complement
    assign mant_w = 40'(signed'(lin_word[10:0]));
    assign expo_w = 6'(signed'(lin_word[15:11]));
    assign prod_w = mant_w * 40'(SCALE);
    assign rsh_w  = 5'(-expo_w);
    // half an lsb added before a right shift rounds to nearest
    assign half_w  = (expo_w < 0) ? (40'sd1 <<< (rsh_w - 5'd1)) : 40'sd0;
    assign shift_w = (expo_w < 0) ? ((prod_w + half_w) >>> rsh_w) : (prod_w <<< expo_w[3:0]);
    // clamp keeps oversize settings at the usable maximum
    assign lin_value = (shift_w > 40'(OMAX)) ? W'(OMAX) :
                       (shift_w < 40'(OMIN)) ? W'(OMIN) : W'(shift_w);
endmodule // rstfr_lin_decode

// *** rstfr_top.sv ***
// per-channel sequencing timers and fast over/undervoltage fault response
`timescale 1ns/10ps
// Overview of operation
// RQ1 - temperature words decode as 11-bit mantissa times two to 5-bit exponent
// RQ2 - timer words use same format in ms, usable maximum 655 ms
// RQ3 - timers advance on a 10 us tick synchronised by the share clock
// RQ4 - each duration rounds to the nearest whole 10 us tick
// RQ5 - after on permission, wait turn-on delay on share clock, then enable
// RQ6 - with servo mode 00, wait ramp time then soft-connect the dac
// RQ7 - undervoltage masked after enable until timeout; zero timeout means no limit
// RQ8 - after off request, soft-disable after turn-off delay, share clock else internal
// RQ9 - fault sets channel, summary word and byte status and pulls alert low
// RQ10 - odd channel in high-resolution mode ignores over/undervoltage faults
// RQ11 - action 00 keeps the channel running after the fault
// RQ12 - action 01 runs the sample count, then applies the retry policy
// RQ13 - action 1x shuts the channel down, then follows the retry policy
// RQ14 - retry 000 keeps the output off until faults are cleared
// RQ15 - nonzero retry restarts after the restart delay until off or another fault
// RQ16 - sample count de-glitches a new fault; 000 acts at the first sample
// RQ17 - reaction byte holds action 7:6, retry 5:3, sample count 2:0
module rstfr_top
    import rstfr_pkg::*;
#(
    parameter bit CHAN_ODD    = 1'b0,
    parameter int RETRY_TICKS = 100
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // register port
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    output logic             reg_rd_valid,
    // pins and supervisor inputs
    input  wire logic        channel_on_request_pin,
    input  wire logic        share_clk,
    input  wire logic        ov_raw,
    input  wire logic        uv_raw,
    // rail control and alert
    output logic             supply_enable,
    output logic             dac_soft_connect,
    output logic             uv_fault_masked,
    output logic             alert_out_n,
    // decoded temperature limits in 1/16 degree
    output logic [15:0]      over_temp_fault_threshold_q4,
    output logic [15:0]      over_temp_warning_threshold_q4,
    output logic [15:0]      under_temp_warning_threshold_q4,
    output logic [15:0]      under_temp_fault_threshold_q4
);
    // ****************************************
    // registers
    // ****************************************
    logic [15:0]  temp_word_r [4];
    logic [15:0]  tmr_word_r  [4];
    logic [7:0]   react_r     [2];
    logic [15:0]  ctrl_r;
    logic [3:0]   status_r;
    logic [15:0]  rdata_r;
    logic         rd_valid_r;
    logic signed [15:0] temp_val_w [4];
    logic signed [16:0] tick_val_w [4];
    logic signed [15:0] temp_val_r [4];

    // write strobes
    logic [3:0] wr_temp_w;
    logic [3:0] wr_tmr_w;
    logic [1:0] wr_react_w;
    logic       wr_ctrl_w;
    logic       clr_w;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dec
            assign wr_temp_w[gi] = reg_wr_en && (reg_addr == REG_OT_FAULT + 8'(gi));
            assign wr_tmr_w[gi]  = reg_wr_en && (reg_addr == REG_TON_WAIT + 8'(gi));
            // RQ1 temperature word decode
            rstfr_lin_decode #(
                .SCALE (TEMP_SCALE),
                .OMIN  (-32768),
                .OMAX  (32767),
                .W     (16)
            ) u_temp (
                .lin_word  (temp_word_r[gi]),
                .lin_value (temp_val_w[gi])
            );
            // RQ2 RQ4 timer word to rounded ticks
            rstfr_lin_decode #(
                .SCALE (TICKS_PER_MS),
                .OMIN  (0),
                .OMAX  (TIMER_MAX_TICKS),
                .W     (17)
            ) u_tmr (
                .lin_word  (tmr_word_r[gi]),
                .lin_value (tick_val_w[gi])
            );
        end
    endgenerate
    assign wr_react_w[0] = reg_wr_en && (reg_addr == REG_OV_REACT);
    assign wr_react_w[1] = reg_wr_en && (reg_addr == REG_OV_REACT + 8'h01);
    assign wr_ctrl_w     = reg_wr_en && (reg_addr == REG_CTRL);
    assign clr_w         = reg_wr_en && (reg_addr == REG_CLEAR);

    // configuration storage
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) begin
                temp_word_r[i] <= WORD_RST;
                tmr_word_r[i]  <= WORD_RST;
                temp_val_r[i]  <= 16'sh0000;
            end
            react_r[0] <= REACT_RST;
            react_r[1] <= REACT_RST;
            ctrl_r     <= CTRL_RST;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_temp_w[i]) temp_word_r[i] <= reg_wdata;
                if (wr_tmr_w[i]) tmr_word_r[i] <= reg_wdata;
                temp_val_r[i] <= temp_val_w[i];
            end
            for (int k = 0; k < 2; k++) begin
                if (wr_react_w[k]) react_r[k] <= reg_wdata[7:0];
            end
            if (wr_ctrl_w) ctrl_r <= reg_wdata;
        end
    end
    assign over_temp_fault_threshold_q4 = temp_val_r[0];
    assign over_temp_warning_threshold_q4  = temp_val_r[1];
    assign under_temp_warning_threshold_q4  = temp_val_r[2];
    assign under_temp_fault_threshold_q4 = temp_val_r[3];

    // timer targets in ticks
    logic [16:0] ton_ticks;
    logic [16:0] rise_ticks;
    logic [16:0] tmo_ticks;
    logic [16:0] toff_ticks;
    assign ton_ticks  = tick_val_w[0];
    assign rise_ticks = tick_val_w[1];
    assign tmo_ticks  = tick_val_w[2];
    assign toff_ticks = tick_val_w[3];

    // ****************************************
    // timebase
    // ****************************************
    logic [7:0] div_r;
    logic [7:0] smp_r;
    logic [1:0] loss_r;
    logic       share_d_r;
    logic       share_edge;
    logic       int_tick;
    logic       share_ok;
    logic       off_tick;
    logic       sample_en;

    assign share_edge = share_clk && !share_d_r;
    assign int_tick   = (div_r == 8'(TICK_CYC - 1));
    assign sample_en  = (smp_r == 8'(SAMPLE_CYC - 1));
    assign share_ok   = (loss_r < 2'(SHARE_LOSS_TICKS));
    // RQ8 off delay falls back to internal tick
    assign off_tick   = share_ok ? share_edge : int_tick;

    // RQ3 share edge realigns the 10 us divider
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_r     <= 8'h00;
            smp_r     <= 8'h00;
            loss_r    <= 2'(SHARE_LOSS_TICKS);
            share_d_r <= 1'b0;
        end else begin
            share_d_r <= share_clk;
            div_r     <= (share_edge || int_tick) ? 8'h00 : div_r + 8'h01;
            smp_r     <= sample_en ? 8'h00 : smp_r + 8'h01;
            if (share_edge) loss_r <= 2'h0;
            else if (int_tick && !share_ok) loss_r <= loss_r;
            else if (int_tick) loss_r <= loss_r + 2'h1;
        end
    end

    // ****************************************
    // fault detection
    // ****************************************
    rstfr_state_t state_r;
    rstfr_state_t state_nxt;
    logic [2:0] glitch_r [2];
    logic [1:0] raw_eff;
    logic [1:0] det;
    logic [1:0] shut_k;
    logic       ignore_w;
    logic       shut_req;
    logic       supply_en_r;
    logic       uv_mask_r;
    logic [2:0] retry_sel_r;

    // RQ10 odd channel in high-resolution mode
    assign ignore_w   = CHAN_ODD && ctrl_r[CTRL_HRS];
    assign raw_eff[0] = ov_raw && !ignore_w;
    assign raw_eff[1] = uv_raw && !ignore_w && supply_en_r && !uv_mask_r;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_flt
            // RQ16 RQ17 fault counted for sample count samples
            assign det[gi] = sample_en && raw_eff[gi] && (glitch_r[gi] >= react_r[gi][DLY_LO +: 3]);
            // RQ11 RQ12 RQ13 only nonzero action shuts down
            assign shut_k[gi] = det[gi] && (react_r[gi][ACT_LO +: 2] != 2'b00);
        end
    endgenerate
    assign shut_req = |shut_k;

    // de-glitch counters restart whenever the fault drops out
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            glitch_r[0] <= 3'h0;
            glitch_r[1] <= 3'h0;
        end else if (sample_en) begin
            for (int k = 0; k < 2; k++) begin
                if (!raw_eff[k]) glitch_r[k] <= 3'h0;
                else if (glitch_r[k] != 3'h7) glitch_r[k] <= glitch_r[k] + 3'h1;
            end
        end
    end

    // RQ9 status set wins over clear, alert follows
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status_r <= 4'h0;
        end else begin
            status_r[ST_OV]   <= (status_r[ST_OV] && !clr_w) || det[0];
            status_r[ST_UV]   <= (status_r[ST_UV] && !clr_w) || det[1];
            status_r[ST_WORD] <= (status_r[ST_WORD] && !clr_w) || |det;
            status_r[ST_BYTE] <= (status_r[ST_BYTE] && !clr_w) || |det;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    logic [16:0] tmr_r;
    logic [16:0] tmo_r;
    logic [16:0] target_w;
    logic        cnt_tick;
    logic        done_w;
    logic        on_allowed;
    logic        dac_conn_r;
    logic        tmo_done;

    // pin only gates when the pin-use bit is set
    assign on_allowed = ctrl_r[CTRL_ON] && (channel_on_request_pin || !ctrl_r[CTRL_PIN]);
    // RQ5 RQ6 on-side timers count share edges only
    assign cnt_tick = (state_r == S_ON_WAIT || state_r == S_RAMP) ? share_edge :
                      (state_r == S_OFF_WAIT) ? off_tick :
                      (state_r == S_FAULT) ? int_tick : 1'b0;
    assign target_w = (state_r == S_ON_WAIT) ? ton_ticks :
                      (state_r == S_RAMP) ? rise_ticks :
                      (state_r == S_OFF_WAIT) ? toff_ticks : 17'(RETRY_TICKS);
    assign done_w   = (tmr_r >= target_w);
    // RQ7 zero timeout never lifts the mask by time
    assign tmo_done = (tmo_ticks != 17'h0) && (tmo_r >= tmo_ticks);

    // next-state selection
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            S_OFF: begin
                if (on_allowed) state_nxt = S_ON_WAIT;
            end
            S_ON_WAIT: begin
                if (!on_allowed) state_nxt = S_OFF;
                else if (done_w) state_nxt = S_RAMP;
            end
            S_RAMP: begin
                if (shut_req) state_nxt = S_FAULT;
                else if (!on_allowed) state_nxt = S_OFF_WAIT;
                else if (done_w || ctrl_r[CTRL_DAC +: 2] != 2'b00) state_nxt = S_UP;
            end
            S_UP: begin
                if (shut_req) state_nxt = S_FAULT;
                else if (!on_allowed) state_nxt = S_OFF_WAIT;
            end
            S_OFF_WAIT: begin
                // RQ8 soft-off once the delay is spent
                if (shut_req) state_nxt = S_FAULT;
                else if (on_allowed) state_nxt = S_UP;
                else if (done_w) state_nxt = S_OFF;
            end
            S_FAULT: begin
                // RQ14 RQ15 retry policy of the shutting fault
                if (!on_allowed) state_nxt = S_OFF;
                else if (retry_sel_r == 3'h0) state_nxt = clr_w ? S_OFF : S_FAULT;
                else if (done_w) state_nxt = S_ON_WAIT;
            end
        endcase
    end

    // state, timer and rail outputs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r     <= S_OFF;
            tmr_r       <= 17'h0;
            supply_en_r <= 1'b0;
            dac_conn_r  <= 1'b0;
            retry_sel_r <= 3'h0;
        end else begin
            state_r     <= state_nxt;
            tmr_r       <= (state_nxt != state_r) ? 17'h0 : tmr_r + {16'h0, cnt_tick && !done_w};
            supply_en_r <= (state_nxt == S_RAMP || state_nxt == S_UP || state_nxt == S_OFF_WAIT);
            // RQ6 soft connect only in servo mode 00
            if (state_r == S_RAMP && state_nxt == S_UP) dac_conn_r <= (ctrl_r[CTRL_DAC +: 2] == 2'b00);
            else if (state_nxt != S_UP && state_nxt != S_OFF_WAIT) dac_conn_r <= 1'b0;
            if (shut_req) retry_sel_r <= shut_k[0] ? react_r[0][RETRY_LO +: 3] : react_r[1][RETRY_LO +: 3];
        end
    end

    // RQ7 undervoltage mask from enable to timeout or good output
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            uv_mask_r <= 1'b1;
            tmo_r     <= 17'h0;
        end else if (!supply_en_r) begin
            uv_mask_r <= 1'b1;
            tmo_r     <= 17'h0;
        end else begin
            if (tmo_done || !uv_raw) uv_mask_r <= 1'b0;
            if (uv_mask_r && share_edge && !tmo_done) tmo_r <= tmo_r + 17'h1;
        end
    end

    // ****************************************
    // register read back
    // ****************************************
    logic [15:0] rd_mux;
    logic [7:0]  rd_idx;
    assign rd_idx = reg_addr - REG_TON_WAIT;
    assign rd_mux = (reg_addr < REG_TON_WAIT) ? temp_word_r[reg_addr[1:0]] :
                    (reg_addr < REG_OV_REACT) ? tmr_word_r[rd_idx[1:0]] :
                    (reg_addr == REG_OV_REACT) ? {8'h00, react_r[0]} :
                    (reg_addr == REG_OV_REACT + 8'h01) ? {8'h00, react_r[1]} :
                    (reg_addr == REG_CTRL) ? ctrl_r :
                    (reg_addr == REG_STATUS) ? {8'h00, state_r, uv_mask_r, status_r} :
                    16'h0000;

    // read data is held until the next read
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r    <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= reg_rd_en;
            if (reg_rd_en) rdata_r <= rd_mux;
        end
    end

    assign reg_rdata        = rdata_r;
    assign reg_rd_valid     = rd_valid_r;
    assign supply_enable    = supply_en_r;
    assign dac_soft_connect = dac_conn_r;
    assign uv_fault_masked  = uv_mask_r;
    assign alert_out_n      = !(|status_r);

    // ****************************************
    // checks
    // ****************************************
    AST_TICK_GAP: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ3
        int_tick |=> !int_tick [*8]) else $error("10 us tick repeated too soon");
    AST_TIMER_CAP: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ2
        ton_ticks <= 17'(TIMER_MAX_TICKS) && toff_ticks <= 17'(TIMER_MAX_TICKS))
        else $error("timer target beyond usable maximum");
    AST_ON_DELAY: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ5
        $rose(supply_en_r) && $past(state_r) == S_ON_WAIT |-> $past(tmr_r) >= $past(ton_ticks))
        else $error("supply enabled before turn-on delay");
    AST_RAMP_CONNECT: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ6
        $rose(dac_conn_r) |-> $past(ctrl_r[2:1]) == 2'b00 && $past(tmr_r) >= $past(rise_ticks))
        else $error("dac connected early or in wrong mode");
    AST_UV_MASKED: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ7
        uv_mask_r |-> !det[1]) else $error("undervoltage acted while masked");
    AST_OFF_DELAY: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ8
        $fell(supply_en_r) && $past(state_r) == S_OFF_WAIT && state_r == S_OFF
        |-> $past(tmr_r) >= $past(toff_ticks))
        else $error("soft-off before turn-off delay");
    AST_ALERT: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ9
        |det |=> !alert_out_n && status_r[ST_WORD] && status_r[ST_BYTE])
        else $error("fault without status and alert");
    AST_HIRES: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ10
        ignore_w |-> det == 2'b00) else $error("high-resolution channel reacted to fault");
    AST_ACT_KEEP: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ11
        det[0] && !det[1] && react_r[0][7:6] == 2'b00 |-> !shut_req)
        else $error("action 00 shut the channel down");
    AST_SHUTDOWN: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ13
        shut_req && supply_en_r |=> !supply_en_r ##1 state_r == S_FAULT || state_r == S_OFF)
        else $error("fault did not shut channel");
    AST_RETRY_NONE: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ14
        state_r == S_FAULT && retry_sel_r == 3'h0 && on_allowed && !clr_w |=> state_r == S_FAULT)
        else $error("channel restarted with retry 000");
    AST_RETRY_STOP: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ15
        state_r == S_FAULT && !on_allowed |=> state_r == S_OFF && !supply_en_r)
        else $error("retry continued after off command");
    AST_GLITCH: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ16
        det[0] && react_r[0][2:0] != 3'h0 |-> $past(raw_eff[0], SAMPLE_CYC))
        else $error("fault acted before sample count");
endmodule // rstfr_top

// *** rstfr_rail_model.sv ***
// rail partner: share clock source and supervisor fault levels
`timescale 1ns/10ps
module rstfr_rail_model (
    // clock
    input  wire logic clk_sys,
    // bench controls
    input  wire logic share_run,
    input  wire logic ov_force,
    input  wire logic uv_force,
    // pins toward the block
    output logic      share_clk,
    output logic      ov_raw,
    output logic      uv_raw
);
    logic [5:0] half_cnt_r;
    // known levels before the first edge
    initial begin
        share_clk  = 1'b0;
        half_cnt_r = 6'h00;
        ov_raw     = 1'b0;
        uv_raw     = 1'b1;
    end
    // 100 kHz share clock
    // stands still when stopped, so the block must notice the loss itself
    always @(posedge clk_sys) begin
        half_cnt_r <= (half_cnt_r == 6'h31 || !share_run) ? 6'h00 : half_cnt_r + 6'h01;
        if (half_cnt_r == 6'h31) share_clk <= ~share_clk;
        ov_raw <= ov_force;
        uv_raw <= uv_force;
    end
endmodule // rstfr_rail_model

// *** rstfr_top_bench.sv ***
// self-checking bench for the rail sequencer and fault response
`timescale 1ns/10ps
module rstfr_top_bench;
    import rstfr_pkg::*;
    // ****************************************
    // stimulus and observation
    // ****************************************
    logic        clk_sys   = 1'b0;
    logic        reset_n   = 1'b0;
    logic        reg_wr_en = 1'b0;
    logic        reg_rd_en = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        share_run = 1'b0;
    logic        ov_force  = 1'b0;
    logic        uv_force  = 1'b1;
    logic        on_pin    = 1'b1;
    logic [15:0] reg_rdata, rd_d, ot_q, otw_q, utw_q, ut_q;
    logic        reg_rd_valid, share_clk, ov_raw, uv_raw, supply_enable, dac_soft_connect, uv_fault_masked, alert_out_n;
    int          n_mismatch = 0;
    int          checked    = 0;
    int          n_share    = 0;
    int          s0;
    rstfr_top #(.CHAN_ODD(1'b1), .RETRY_TICKS(2)) rstfr_top_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .channel_on_request_pin(on_pin),
        .share_clk(share_clk), .ov_raw(ov_raw), .uv_raw(uv_raw), .supply_enable(supply_enable),
        .dac_soft_connect(dac_soft_connect), .uv_fault_masked(uv_fault_masked), .alert_out_n(alert_out_n),
        .over_temp_fault_threshold_q4(ot_q), .over_temp_warning_threshold_q4(otw_q), .under_temp_warning_threshold_q4(utw_q), .under_temp_fault_threshold_q4(ut_q));
    rstfr_rail_model rstfr_rail_model_inst (.clk_sys(clk_sys), .share_run(share_run), .ov_force(ov_force),
        .uv_force(uv_force), .share_clk(share_clk), .ov_raw(ov_raw), .uv_raw(uv_raw));
    // clock and share edge count; outputs are sampled on falling edges
    always #50 clk_sys = ~clk_sys;
    always @(posedge share_clk) n_share++;
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic pause(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
    endtask
    // read strobe, then sample data in the valid cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        pause(1);
        chk1(reg_rd_valid, 1'b1);
        rd_d = reg_rdata;
    endtask
    task automatic wait_sup(input logic lvl, input int lim);
        for (int i = 0; i < lim && supply_enable !== lvl; i++) @(negedge clk_sys);
        chk1(supply_enable, lvl);
    endtask
    // drop the fault, let a sample pass, then clear status
    task automatic clear_ov;
        @(posedge clk_sys) ov_force <= 1'b0;
        pause(300);
        wr(REG_CLEAR, 16'h0000);
        pause(3);
        chk1(alert_out_n, 1'b1);
    endtask
    task automatic t_regs;
        wr(8'h3F, 16'hFFFF);
        rd(8'h3F);
        chk16(rd_d, 16'h0000);
        rd(REG_TON_WAIT);
        chk16(rd_d, WORD_RST);
        wr(REG_OT_FAULT, 16'hF832);
        wr(REG_OT_FAULT + 8'h03, 16'h07F6);
        pause(3);
        chk16(ot_q, 16'h0190);
        chk16(ut_q, 16'hFF60);
        wr(REG_OV_REACT, 16'h004B);
        rd(REG_OV_REACT);
        chk16(rd_d, 16'h004B);
    endtask
    // on delay 2.34 ticks and ramp 2.73 ticks round to 2 and 3 share edges
    task automatic t_on_seq;
        wr(REG_TON_WAIT, 16'hC803);
        wr(REG_TON_WAIT + 8'h01, 16'hC007);
        wr(REG_TON_WAIT + 8'h03, 16'hC803);
        wr(REG_CTRL, 16'h0009);
        pause(500);
        chk1(supply_enable, 1'b0);
        @(posedge clk_sys) share_run <= 1'b1;
        s0 = n_share;
        wait_sup(1'b1, 1000);
        chk16(16'(n_share - s0), 16'h0002);
        s0 = n_share;
        for (int i = 0; i < 1000 && dac_soft_connect !== 1'b1; i++) @(negedge clk_sys);
        chk1(dac_soft_connect, 1'b1);
        chk16(16'(n_share - s0), 16'h0003);
        pause(700);
        chk1(uv_fault_masked, 1'b1);
        @(posedge clk_sys) uv_force <= 1'b0;
        pause(300);
        chk1(uv_fault_masked, 1'b0);
    endtask
    task automatic t_act_none;
        wr(REG_OV_REACT, 16'h0000);
        wr(REG_CTRL, 16'h0019);
        @(posedge clk_sys) ov_force <= 1'b1;
        pause(600);
        chk1(alert_out_n, 1'b1);
        wr(REG_CTRL, 16'h0009);
        pause(600);
        chk1(supply_enable, 1'b1);
        chk1(alert_out_n, 1'b0);
        rd(REG_STATUS);
        chk16(rd_d & 16'h000D, 16'h000D);
        clear_ov;
    endtask
    // action 01, retry 001, three samples of de-glitch
    task automatic t_retry;
        wr(REG_OV_REACT, 16'h004B);
        @(posedge clk_sys) ov_force <= 1'b1;
        pause(200);
        @(posedge clk_sys) ov_force <= 1'b0;
        pause(600);
        chk1(supply_enable, 1'b1);
        clear_ov;
        @(posedge clk_sys) ov_force <= 1'b1;
        pause(200);
        chk1(supply_enable, 1'b1);
        wait_sup(1'b0, 800);
        @(posedge clk_sys) ov_force <= 1'b0;
        wait_sup(1'b1, 3000);
        clear_ov;
    endtask
    task automatic t_latch;
        wr(REG_OV_REACT, 16'h0080);
        @(posedge clk_sys) ov_force <= 1'b1;
        wait_sup(1'b0, 400);
        @(posedge clk_sys) ov_force <= 1'b0;
        pause(2000);
        chk1(supply_enable, 1'b0);
        clear_ov;
    endtask
    // share clock stops, so the off delay falls back to the internal tick
    task automatic t_off;
        wait_sup(1'b1, 1500);
        @(posedge clk_sys) share_run <= 1'b0;
        @(posedge clk_sys) on_pin <= 1'b0;
        pause(150);
        chk1(supply_enable, 1'b1);
        wait_sup(1'b0, 1500);
    endtask
    task automatic tally_and_finish;
        $display("checks made %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // main sequence, and a watchdog well past the expected 0.9 ms
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_regs;
        t_on_seq;
        t_act_none;
        t_retry;
        t_latch;
        t_off;
        tally_and_finish;
    end
    initial begin
        #5ms;
        n_mismatch++;
        tally_and_finish;
    end
endmodule // rstfr_top_bench
